// file: rtl/ocrm_top.sv
// Oscillator control register bank behind a two-wire serial slave
`timescale 1ns/100ps
module ocrm_top #(
  parameter int CAL_CYCLES_P = ocrm_pkg::CAL_CYCLES
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Serial bus pins
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  // Synthesis settings and status
  output logic CLK_OUT_O,
  output ocrm_pkg::ocrm_cfg_t OSC_CFG_O,
  output logic CAL_BUSY_O,
  output logic FB_INT_VALID_O
);
  import ocrm_pkg::*;

  logic scl_s, sda_s, scl_d, sda_d;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  ocrm_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic rw_r, addr_phase_r, nack_r, sda_oe_r;
  logic [7:0] ptr_r;
  ocrm_wr_t wr_r;
  logic [7:0] rdata;
  ocrm_cfg_t cfg_r;
  logic [7:0] fine0_r, fine1_r;
  logic cal_byp_r;
  logic [1:0] page_r;
  logic soft_rst_r;
  logic bank_rst_n;
  logic cal_busy_r;
  logic [20:0] cal_cnt_r;
  logic fb_valid_r;
  logic pg0_wr;
  logic cal_cmd;

  // Pin synchronisers
  ocrm_sync #(.W(2)) u_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .async_i({SCL_I, SDA_I}),
    .sync_o({scl_s, sda_s})
  );

  // Previous levels for edge and condition detection
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Our own data drive changes only while the clock is low, so it never fakes a start or stop
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop = scl_s && scl_d && !sda_d && sda_s;

  // Serial slave engine with auto-incrementing register pointer
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      rw_r <= 1'b0;
      addr_phase_r <= 1'b0;
      nack_r <= 1'b0;
      sda_oe_r <= 1'b0;
      ptr_r <= 8'h00;
      wr_r <= '0;
    end else begin
      wr_r.stb <= 1'b0;
      if (bus_stop) begin
        state_r <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end else if (bus_start) begin
        state_r <= ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
      end else if (scl_rise) begin
        case (state_r)
          ST_ADDR, ST_WR: begin
            shift_r <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          ST_RD: begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          ST_RD_ACK: begin
            nack_r <= sda_s;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state_r)
          ST_ADDR: begin
            if (bit_cnt_r == 4'h8) begin
              if (shift_r[7:1] == BUS_ADDR) begin
                state_r <= ST_ADDR_ACK;
                sda_oe_r <= 1'b1;
                rw_r <= shift_r[0];
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK: begin
            bit_cnt_r <= 4'h0;
            if (rw_r) begin
              state_r <= ST_RD;
              tx_r <= rdata;
              sda_oe_r <= !rdata[7];
            end else begin
              state_r <= ST_WR;
              sda_oe_r <= 1'b0;
              addr_phase_r <= 1'b1;
            end
          end
          ST_WR: begin
            if (bit_cnt_r == 4'h8) begin
              state_r <= ST_WR_ACK;
              sda_oe_r <= 1'b1;
              if (addr_phase_r) begin
                ptr_r <= shift_r;
                addr_phase_r <= 1'b0;
              end else begin
                wr_r.stb <= 1'b1;
                wr_r.addr <= ptr_r;
                wr_r.data <= shift_r;
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
          ST_WR_ACK: begin
            state_r <= ST_WR;
            bit_cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
          end
          ST_RD: begin
            if (bit_cnt_r == 4'h8) begin
              state_r <= ST_RD_ACK;
              sda_oe_r <= 1'b0;
              ptr_r <= ptr_r + 8'h01;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe_r <= !tx_r[6];
            end
          end
          ST_RD_ACK: begin
            if (!nack_r) begin
              state_r <= ST_RD;
              bit_cnt_r <= 4'h0;
              tx_r <= rdata;
              sda_oe_r <= !rdata[7];
            end else begin
              state_r <= ST_IDLE;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Open-drain data pin: only ever pulled low
  assign SDA_O = 1'b0;
  assign SDA_OE_O = sda_oe_r;

  // page bits extend the address; page register reachable from every page
  always_comb begin
    rdata = 8'h00;
    if (ptr_r == ADDR_PAGE) begin
      rdata = {6'h00, page_r};
    end else if (page_r == PAGE_ZERO) begin
      case (ptr_r)
        ADDR_PART_ID: rdata = PART_ID;
        ADDR_CTRL: rdata = {4'h0, cal_busy_r, 3'h0};
        ADDR_OUT_CTRL: rdata = {7'h00, cfg_r.out_en};
        ADDR_HS_LOW: rdata = cfg_r.hs_div[7:0];
        ADDR_DIV_HIGH: rdata = {1'b0, cfg_r.ls_code, 1'b0, cfg_r.hs_div[10:8]};
        ADDR_FB0: rdata = cfg_r.fb_div[7:0];
        ADDR_FB1: rdata = cfg_r.fb_div[15:8];
        ADDR_FB2: rdata = cfg_r.fb_div[23:16];
        ADDR_FB3: rdata = cfg_r.fb_div[31:24];
        ADDR_FB4: rdata = cfg_r.fb_div[39:32];
        ADDR_FB_TOP: rdata = {5'h00, cfg_r.fb_div[42:40]};
        ADDR_CAL_BYP: rdata = {7'h00, cal_byp_r};
        ADDR_FINE0: rdata = fine0_r;
        ADDR_FINE1: rdata = fine1_r;
        ADDR_FINE2: rdata = cfg_r.fine[23:16];
        default: rdata = 8'h00;
      endcase
    end
  end

  assign pg0_wr = wr_r.stb && (page_r == PAGE_ZERO);
  assign cal_cmd = pg0_wr && (wr_r.addr == ADDR_CTRL) && wr_r.data[CTRL_CAL_BIT];

  // one-cycle soft reset pulse, self clearing
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= pg0_wr && (wr_r.addr == ADDR_CTRL) && wr_r.data[CTRL_RESET_BIT];
    end
  end
  assign bank_rst_n = RST_N_I && !soft_rst_r;

  // reset values; field packing; written reserved bits dropped
  always_ff @(posedge CLK_I) begin
    if (!bank_rst_n) begin
      cfg_r.out_en <= RST_OUT_EN;
      cfg_r.hs_div <= RST_HS_DIV;
      cfg_r.ls_code <= RST_LS_CODE;
      cfg_r.fb_div <= RST_FB_DIV;
      cal_byp_r <= RST_CAL_BYP;
      fine0_r <= RST_FINE[7:0];
      fine1_r <= RST_FINE[15:8];
      cfg_r.fine <= RST_FINE;
    end else if (pg0_wr) begin
      case (wr_r.addr)
        ADDR_OUT_CTRL: cfg_r.out_en <= wr_r.data[OUT_EN_BIT];
        ADDR_HS_LOW: cfg_r.hs_div[7:0] <= wr_r.data;
        ADDR_DIV_HIGH: begin
          cfg_r.hs_div[10:8] <= wr_r.data[2:0];
          cfg_r.ls_code <= wr_r.data[LS_LSB +: 3];
        end
        ADDR_FB0: cfg_r.fb_div[7:0] <= wr_r.data;
        ADDR_FB1: cfg_r.fb_div[15:8] <= wr_r.data;
        ADDR_FB2: cfg_r.fb_div[23:16] <= wr_r.data;
        ADDR_FB3: cfg_r.fb_div[31:24] <= wr_r.data;
        ADDR_FB4: cfg_r.fb_div[39:32] <= wr_r.data;
        ADDR_FB_TOP: cfg_r.fb_div[42:40] <= wr_r.data[2:0];
        ADDR_CAL_BYP: cal_byp_r <= wr_r.data[0];
        // fine offset staged low bytes, committed on top byte
        // Kept in this block so the settings word has a single driver
        ADDR_FINE0: fine0_r <= wr_r.data;
        ADDR_FINE1: fine1_r <= wr_r.data;
        ADDR_FINE2: cfg_r.fine <= {wr_r.data, fine1_r, fine0_r};
        default: begin
        end
      endcase
    end
  end

  // page select written from any page
  always_ff @(posedge CLK_I) begin
    if (!bank_rst_n) begin
      page_r <= RST_PAGE;
    end else if (wr_r.stb && wr_r.addr == ADDR_PAGE) begin
      page_r <= wr_r.data[1:0];
    end
  end

  // calibration timer; skipped under bypass. A retrigger restarts the wait.
  always_ff @(posedge CLK_I) begin
    if (!bank_rst_n) begin
      cal_busy_r <= 1'b0;
      cal_cnt_r <= 21'h000000;
    end else if (cal_cmd && !cal_byp_r) begin
      cal_busy_r <= 1'b1;
      cal_cnt_r <= 21'(CAL_CYCLES_P - 1);
    end else if (cal_busy_r) begin
      if (cal_cnt_r == 21'h000000) begin
        cal_busy_r <= 1'b0;
      end else begin
        cal_cnt_r <= cal_cnt_r - 21'h000001;
      end
    end
  end

  // integer part range flag, one cycle behind the word
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      fb_valid_r <= 1'b0;
    end else begin
      fb_valid_r <= (cfg_r.fb_div[42:32] >= FB_INT_MIN) && (cfg_r.fb_div[42:32] <= FB_INT_MAX);
    end
  end

  // Output clock generation
  ocrm_clkdiv u_clkdiv (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .en_i(cfg_r.out_en),
    .hs_div_i(cfg_r.hs_div),
    .ls_code_i(cfg_r.ls_code),
    .clk_o(CLK_OUT_O)
  );

  assign OSC_CFG_O = cfg_r;
  assign CAL_BUSY_O = cal_busy_r;
  assign FB_INT_VALID_O = fb_valid_r;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_rst_cmd;
    pg0_wr && wr_r.addr == ADDR_CTRL && wr_r.data[CTRL_RESET_BIT];
  endsequence
  sequence s_rst_done;
    !soft_rst_r && cfg_r.out_en && cal_byp_r && page_r == 2'h0 && !cal_busy_r && cfg_r.hs_div == 11'h054;
  endsequence

  a_part_id_read: assert property ((page_r == 2'h0 && ptr_r == 8'h00) |-> rdata == PART_ID)
    else $error("part identifier reads wrong");
  a_soft_reset_clear: assert property (s_rst_cmd |=> soft_rst_r ##1 s_rst_done)
    else $error("soft reset did not restore and clear");
  a_cal_start_busy: assert property ((cal_cmd && !cal_byp_r && !wr_r.data[7]) |=> cal_busy_r)
    else $error("calibration did not start");
  a_cal_bypass_skip: assert property ((cal_cmd && cal_byp_r && !cal_busy_r) |=> !cal_busy_r)
    else $error("calibration ran while bypassed");
  a_hs_div_pack: assert property ((pg0_wr && wr_r.addr == ADDR_DIV_HIGH) |=>
      (cfg_r.hs_div[10:8] == $past(wr_r.data[2:0]) && cfg_r.ls_code == $past(wr_r.data[6:4])))
    else $error("packed divider register misplaced");
  a_fine_low_hold: assert property ((pg0_wr && (wr_r.addr == ADDR_FINE0 || wr_r.addr == ADDR_FINE1))
      |=> $stable(cfg_r.fine))
    else $error("fine offset changed before top byte");
  a_fine_top_commit: assert property ((pg0_wr && wr_r.addr == ADDR_FINE2) |=>
      cfg_r.fine == {$past(wr_r.data), fine1_r, fine0_r})
    else $error("fine offset not committed");
  a_page_write_gate: assert property ((wr_r.stb && page_r != 2'h0 && wr_r.addr == ADDR_OUT_CTRL)
      |=> $stable(cfg_r.out_en))
    else $error("write outside page zero landed");
  a_reserved_read_zero: assert property ((page_r == 2'h0 && ptr_r == ADDR_DIV_HIGH) |->
      (rdata[7] == 1'b0 && rdata[3] == 1'b0))
    else $error("unused bits read nonzero");
  a_fb_range_flag: assert property (RST_N_I |=> fb_valid_r ==
      ($past(cfg_r.fb_div[42:32]) >= 11'h03C && $past(cfg_r.fb_div[42:32]) <= 11'h7FD))
    else $error("feedback integer range flag wrong");

endmodule : ocrm_top

// file: rtl/ocrm_pkg.sv
// Package with register map, field layout, reset values and timing for the oscillator control bank
package ocrm_pkg;

  // Register offsets within page zero
  localparam logic [7:0] ADDR_PART_ID = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h07;
  localparam logic [7:0] ADDR_OUT_CTRL = 8'h11;
  localparam logic [7:0] ADDR_HS_LOW = 8'h17;
  localparam logic [7:0] ADDR_DIV_HIGH = 8'h18;
  localparam logic [7:0] ADDR_FB0 = 8'h1A;
  localparam logic [7:0] ADDR_FB1 = 8'h1B;
  localparam logic [7:0] ADDR_FB2 = 8'h1C;
  localparam logic [7:0] ADDR_FB3 = 8'h1D;
  localparam logic [7:0] ADDR_FB4 = 8'h1E;
  localparam logic [7:0] ADDR_FB_TOP = 8'h1F;
  localparam logic [7:0] ADDR_CAL_BYP = 8'h45;
  localparam logic [7:0] ADDR_FINE0 = 8'hE7;
  localparam logic [7:0] ADDR_FINE1 = 8'hE8;
  localparam logic [7:0] ADDR_FINE2 = 8'hE9;
  localparam logic [7:0] ADDR_PAGE = 8'hFF;
  localparam logic [1:0] PAGE_ZERO = 2'h0;

  // Field positions
  localparam int CTRL_RESET_BIT = 7;
  localparam int CTRL_CAL_BIT = 3;
  localparam int OUT_EN_BIT = 0;
  localparam int LS_LSB = 4;

  // Reset values
  localparam logic RST_OUT_EN = 1'b1;
  localparam logic [10:0] RST_HS_DIV = 11'h054;
  localparam logic [2:0] RST_LS_CODE = 3'h0;
  localparam logic [42:0] RST_FB_DIV = 43'h06400000000;
  localparam logic [23:0] RST_FINE = 24'h000000;
  localparam logic RST_CAL_BYP = 1'b1;
  localparam logic [1:0] RST_PAGE = 2'h0;

  // Identity values, both arbitrary
  localparam logic [7:0] PART_ID = 8'h5A;
  localparam logic [6:0] BUS_ADDR = 7'h55;

  // Divider limits
  localparam logic [10:0] FB_INT_MIN = 11'h03C;
  localparam logic [10:0] FB_INT_MAX = 11'h7FD;
  localparam logic [2:0] LS_MAX_CODE = 3'h5;

  // Calibration time
  localparam int CLK_FREQ_KHZ = 50000;
  localparam int CAL_TIME_MS = 30;
  localparam int CAL_CYCLES = CAL_TIME_MS * CLK_FREQ_KHZ;

  // Serial engine states
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK} ocrm_state_t;

  // Frequency settings carried to the synthesis logic
  typedef struct packed {
    logic out_en;
    logic [10:0] hs_div;
    logic [2:0] ls_code;
    logic [42:0] fb_div;
    logic [23:0] fine;
  } ocrm_cfg_t;

  // One byte written by the serial engine
  typedef struct packed {
    logic stb;
    logic [7:0] addr;
    logic [7:0] data;
  } ocrm_wr_t;

endpackage : ocrm_pkg

// file: rtl/ocrm_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module ocrm_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Asynchronous and synchronised levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  import ocrm_pkg::*;

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          meta_r[gi] <= 1'b1;
          sync_o[gi] <= 1'b1;
        end else begin
          meta_r[gi] <= async_i[gi];
          sync_o[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

endmodule : ocrm_sync

// file: rtl/ocrm_clkdiv.sv
// Output clock divider: high-speed divider times power-of-two divider, gated by enable
`timescale 1ns/100ps
module ocrm_clkdiv (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Settings
  input wire logic en_i,
  input wire logic [10:0] hs_div_i,
  input wire logic [2:0] ls_code_i,
  // Divided clock
  output logic clk_o
);
  import ocrm_pkg::*;

  logic [15:0] div_n;
  logic [15:0] cnt_r;
  logic [2:0] shift;

  // power-of-two ratio, codes above five clip to 32
  always_comb begin
    shift = (ls_code_i > LS_MAX_CODE) ? LS_MAX_CODE : ls_code_i;
    div_n = 16'(hs_div_i) << shift;
  end

  // Period counter, restarts whenever the output is stopped
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !en_i) begin
      cnt_r <= 16'h0000;
    end else if (cnt_r >= div_n - 16'h0001) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      clk_o <= 1'b0;
    end else begin
      clk_o <= en_i && (cnt_r < (div_n >> 1));
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_oe_stop_low: assert property (!en_i |=> (!clk_o && cnt_r == 16'h0000))
    else $error("output clock runs while disabled");
  a_ls_ratio_clip: assert property (ls_code_i >= 3'h5 |-> div_n == (16'(hs_div_i) << 5))
    else $error("power-of-two ratio not clipped at 32");
  a_ls_zero_bypass: assert property (ls_code_i == 3'h0 |-> div_n == 16'(hs_div_i))
    else $error("code zero does not bypass divider");
  a_div_wrap_point: assert property ((en_i && $past(en_i) && cnt_r == div_n - 16'h0001 && $stable(div_n))
      |=> cnt_r == 16'h0000)
    else $error("divider period wrong");

endmodule : ocrm_clkdiv

// file: dv/ocrm_host_model.sv
// Two-wire bus host model that drives the serial pins of the register bank
`timescale 1ns/100ps
module ocrm_host_model (
  // Resolved data wire
  input wire logic sda_i,
  // Pins driven by the host
  output logic scl_o,
  output logic sda_low_o,
  // Results of the last transfer
  output logic [7:0] rd_data_o,
  output logic rd_stb_o,
  output logic ack_o
);
  import ocrm_pkg::*;
  localparam int Q = 40;
  // Idle bus, both lines released to the pull-up
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    rd_data_o = 8'h00;
    rd_stb_o = 1'b0;
    ack_o = 1'b0;
  end
  // Data changes only while the clock is low
  // Pins change by nonblocking assignment, so the sampling edge sees them race-free
  task automatic bit_out(input logic b);
    sda_low_o <= ~b;
    #Q scl_o <= 1'b1;
    #(2*Q) scl_o <= 1'b0;
    #Q;
  endtask : bit_out
  // Sampled late in the high phase, device output has long settled
  task automatic bit_in(output logic b);
    sda_low_o <= 1'b0;
    #Q scl_o <= 1'b1;
    #(2*Q-1) b = sda_i;
    #1 scl_o <= 1'b0;
    #Q;
  endtask : bit_in
  // Start, also usable as a repeated start
  task automatic start();
    sda_low_o <= 1'b0;
    #Q scl_o <= 1'b1;
    #Q sda_low_o <= 1'b1;
    #Q scl_o <= 1'b0;
    #Q;
  endtask : start
  // Stop leaves both lines released
  task automatic stop();
    sda_low_o <= 1'b1;
    #Q scl_o <= 1'b1;
    #Q sda_low_o <= 1'b0;
    #(2*Q);
  endtask : stop
  // Byte out, MSB first; a missing acknowledge clears ack_o
  task automatic send(input logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    bit_in(a);
    if (a) ack_o = 1'b0;
  endtask : send
  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d);
    ack_o = 1'b1;
    start();
    send({BUS_ADDR, 1'b0});
    send(ptr);
    send(d);
    stop();
  endtask : write_reg
  // Pointer write, repeated start, one byte read ended by a not-acknowledge
  task automatic read_reg(input logic [7:0] ptr);
    logic [7:0] b;
    ack_o = 1'b1;
    start();
    send({BUS_ADDR, 1'b0});
    send(ptr);
    start();
    send({BUS_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) bit_in(b[i]);
    bit_out(1'b1);
    stop();
    rd_data_o = b;
    rd_stb_o = 1'b1;
    #20 rd_stb_o = 1'b0;
  endtask : read_reg
  task automatic probe(input logic [6:0] a);
    ack_o = 1'b1;
    start();
    send({a, 1'b0});
    stop();
  endtask : probe
endmodule : ocrm_host_model

// file: dv/ocrm_top_bench.sv
// Self-checking bench for the oscillator control register bank
`timescale 1ns/100ps
module ocrm_top_bench;
  import ocrm_pkg::*;
  localparam int CAL_P = 20;
  localparam int EDGE[4] = '{59, 60, 2045, 2046};
  localparam logic [15:0] RV[9] = '{16'h0000, 16'h0700, 16'h1101, 16'h1754, 16'h1800, 16'h1E64, 16'h1F00,
    16'h4501, 16'hFF00};
  logic CLK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic scl, sda_low, sda_w, rd_stb, hack, SDA_OE_O, CLK_OUT_O, CAL_BUSY_O, FB_INT_VALID_O;
  logic [7:0] rd_data, r8;
  logic [47:0] fb;
  logic [31:0] fine;
  ocrm_cfg_t cfg;
  int failures = 0;
  int checks = 0;
  int busy_cnt = 0;
  int n;
  logic [7:0] exp_q[$];
  // Pull-up on the data wire; either party may pull it low
  assign sda_w = ~(sda_low | SDA_OE_O);
  always #10 CLK_I = ~CLK_I;
  ocrm_top #(.CAL_CYCLES_P(CAL_P)) dut_u (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(),
    .SDA_OE_O(SDA_OE_O), .CLK_OUT_O(CLK_OUT_O), .OSC_CFG_O(cfg), .CAL_BUSY_O(CAL_BUSY_O),
    .FB_INT_VALID_O(FB_INT_VALID_O));
  ocrm_host_model host_u (.sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low), .rd_data_o(rd_data),
    .rd_stb_o(rd_stb), .ack_o(hack));
  // Wide enough for the whole 82-bit settings word
  task automatic check(input logic [95:0] got, input logic [95:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  // Each read byte is compared with the oldest noted value
  always @(posedge rd_stb) begin
    if (exp_q.size() == 0) check({56'h0, rd_data}, 64'hFFFF);
    else check(rd_data, exp_q.pop_front());
  end
  // Calibration busy length, cleared by the main sequence
  always @(posedge CLK_I) if (CAL_BUSY_O === 1'b1) busy_cnt++;
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.read_reg(a);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.write_reg(a, d);
  endtask : wr
  // Rise-to-rise period of the output clock in system cycles
  task automatic clk_period(output int p);
    int k;
    k = 0;
    p = 0;
    while (CLK_OUT_O !== 1'b0 && k < 5000) begin @(posedge CLK_I); k++; end
    while (CLK_OUT_O !== 1'b1 && k < 5000) begin @(posedge CLK_I); k++; end
    do begin @(posedge CLK_I); p++; end while (CLK_OUT_O !== 1'b0 && p < 5000);
    while (CLK_OUT_O !== 1'b1 && p < 5000) begin @(posedge CLK_I); p++; end
  endtask : clk_period
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // Hang guard, about twice the expected run, still under the cycle budget
  initial begin
    #1500000;
    failures++;
    report_and_stop();
  end
  initial begin
    r8 = 8'($urandom(96126));
    repeat (12) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    repeat (4) @(posedge CLK_I);
    check(cfg, {RST_OUT_EN, RST_HS_DIV, RST_LS_CODE, RST_FB_DIV, RST_FINE});
    check(FB_INT_VALID_O, 1'b1);
    rd(ADDR_PART_ID, PART_ID);
    for (int i = 1; i < 9; i++) rd(RV[i][15:8], RV[i][7:0]);
    $display("test reset done");
    r8 = 8'($urandom);
    wr(ADDR_PART_ID, r8);
    rd(ADDR_PART_ID, PART_ID);
    host_u.probe(BUS_ADDR ^ 7'h01);
    check(hack, 1'b0);
    wr(ADDR_DIV_HIGH, 8'hFF);
    check(hack, 1'b1);
    rd(ADDR_DIV_HIGH, 8'h77);
    r8 = 8'($urandom);
    wr(ADDR_HS_LOW, r8);
    check(cfg.hs_div, {3'h7, r8});
    check(cfg.ls_code, 3'h7);
    wr(ADDR_OUT_CTRL, 8'hFE);
    rd(ADDR_OUT_CTRL, 8'h00);
    wr(ADDR_OUT_CTRL, 8'hFF);
    rd(ADDR_OUT_CTRL, 8'h01);
    wr(ADDR_FB_TOP, 8'hFF);
    rd(ADDR_FB_TOP, 8'h07);
    wr(ADDR_CTRL, 8'h77);
    rd(ADDR_CTRL, 8'h00);
    wr(ADDR_PAGE, 8'hFF);
    rd(ADDR_PAGE, 8'h03);
    rd(ADDR_OUT_CTRL, 8'h00);
    wr(ADDR_OUT_CTRL, 8'h00);
    wr(ADDR_PAGE, 8'h00);
    rd(ADDR_OUT_CTRL, 8'h01);
    $display("test fields done");
    // Smallest legal divider, odd values allowed at the low end
    wr(ADDR_HS_LOW, 8'h05);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_DIV_HIGH, {1'b0, 3'(c), 4'h0});
      clk_period(n);
      clk_period(n);
      check(n, 5 << (c > 5 ? 5 : c));
    end
    wr(ADDR_HS_LOW, 8'h21);
    clk_period(n);
    clk_period(n);
    check(n, 33 * 32);
    wr(ADDR_HS_LOW, 8'hFE);
    wr(ADDR_DIV_HIGH, 8'h07);
    wr(ADDR_OUT_CTRL, 8'h00);
    n = 0;
    repeat (300) @(posedge CLK_I) if (CLK_OUT_O !== 1'b0) n++;
    check(n, 0);
    wr(ADDR_OUT_CTRL, 8'h01);
    clk_period(n);
    clk_period(n);
    check(n, 2046);
    $display("test clock done");
    fb = {5'h0, 11'd60, $urandom};
    for (int i = 0; i < 6; i++) wr(8'(ADDR_FB0 + i), fb[8*i +: 8]);
    check(cfg.fb_div, fb[42:0]);
    for (int j = 0; j < 4; j++) begin
      wr(ADDR_FB4, 8'(EDGE[j]));
      wr(ADDR_FB_TOP, 8'(EDGE[j] >> 8));
      check(FB_INT_VALID_O, EDGE[j] >= 60 && EDGE[j] <= 2045);
    end
    // Low bytes first, top byte commits the offset
    fine = $urandom;
    wr(ADDR_FINE0, fine[7:0]);
    wr(ADDR_FINE1, fine[15:8]);
    check(cfg.fine, RST_FINE);
    rd(ADDR_FINE1, fine[15:8]);
    wr(ADDR_FINE2, fine[23:16]);
    check(cfg.fine, fine[23:0]);
    $display("test dividers done");
    busy_cnt = 0;
    wr(ADDR_CTRL, 8'h08);
    repeat (40) @(posedge CLK_I);
    check(busy_cnt, 0);
    wr(ADDR_CAL_BYP, 8'h00);
    busy_cnt = 0;
    wr(ADDR_CTRL, 8'h08);
    repeat (40) @(posedge CLK_I);
    check(busy_cnt, CAL_P);
    rd(ADDR_CTRL, 8'h00);
    wr(ADDR_OUT_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'h80);
    check(hack, 1'b1);
    check(cfg, {RST_OUT_EN, RST_HS_DIV, RST_LS_CODE, RST_FB_DIV, RST_FINE});
    rd(ADDR_CTRL, 8'h00);
    rd(ADDR_CAL_BYP, 8'h01);
    $display("test control done");
    check(exp_q.size(), 0);
    report_and_stop();
  end
endmodule : ocrm_top_bench
